// [ref_clock_source.sv]
// behavioural external reference clock source with one output, fed by the bench to both pins of stage 0
`default_nettype none
module ref_clock_source (
  input  wire logic       core_clk,
  input  wire logic       run,
  input  wire logic [3:0] halfPer,
  output logic            pinOut
);
  timeunit 1ns;
  timeprecision 1ps;

  int cnt = 0;

  initial pinOut = 1'b0;

  // edges land just after the core edge, so the stage samples a settled level
  always @(posedge core_clk) begin
    #1;
    if (!run) begin
      cnt = 0;
    end else if (cnt >= int'(halfPer) - 1) begin
      cnt = 0;
      pinOut = ~pinOut;
    end else begin
      cnt++;
    end
  end
endmodule // ref_clock_source
`default_nettype wire

// [ref_input_pkg.sv]
// shared constants and carrier types for the reference input front end
`default_nettype none
package ref_input_pkg;
  localparam int NUM_STAGES    = 8;
  localparam int NUM_CLKS      = 16;
  localparam int NEG_IDX_OFS   = 8;
  localparam int DIV_W         = 16;
  localparam int FREQ_W        = 32;
  localparam int DIV_MIN       = 2;
  localparam int DIV_MAX       = 65536;
  localparam int MAX_INT_MHZ   = 150;
  localparam int GPIO_STAGE_LO = 0;
  localparam int GPIO_STAGE_HI = 3;
  localparam int GPIO0_CLK_IDX = 8;
  localparam int GPIO3_CLK_IDX = 15;
  localparam int NUM_GPIO      = 4;

  typedef enum logic [1:0] {
    MODE_DIFF      = 2'h0,
    MODE_DUAL_SE   = 2'h1,
    MODE_DIFF_GPIO = 2'h2
  } stage_mode_t;

  // one path: bypass, falling edge, divide ratio minus one
  typedef struct packed {
    logic             bypass;
    logic             invert;
    logic [DIV_W-1:0] divM1;
  } path_cfg_t;

  typedef struct packed {
    logic              enable;
    stage_mode_t       mode;
    path_cfg_t         posPath;
    path_cfg_t         negPath;
    logic              syncUse;
    logic [3:0]        syncAssoc;
    logic [FREQ_W-1:0] input_nominal_frequency_field;
  } stage_cfg_t;

  typedef struct packed {
    logic los;
    logic act;
    logic freq;
  } mon_fail_t;
endpackage : ref_input_pkg
`default_nettype wire

// [ref_input_stage.sv]
// reference clock input stages, index mapping and monitor gating
`default_nettype none
// Overview of operation
// R1 - each stage runs as one differential, two single-ended, or differential plus pin
// R2 - differential-only stage drives the internal clock of its own index
// R3 - each path has an integer pre-divider from 2 to 65536
// R4 - divider can be bypassed, passing the input edge straight through
// R5 - falling-edge lock selected by feeding inverted input to the divider
// R6 - dual single-ended: positive pin at stage index, negative pin at index plus 8
// R7 - dual single-ended paths each own an independent pre-divider
// R8 - edge polarity chosen separately per path in two-path modes
// R9 - internal clock indices are fixed; unpopulated indices stay reserved
// R10 - pin mode only on stages 0-3; pin 0 to clock 8, pin 3 to 15
// R11 - other stages allow only differential or dual single-ended modes
// R12 - pin references bypass division; the paired differential path keeps its divider
// R13 - unused inputs can be disabled to stop toggling
// R14 - any input may act as a sync or frame pulse for another input; the code steers only indices below STAGES to sync
// R15 - software programs each active input's nominal frequency before use
// R16 - one reference monitor instance per input, indices 0 to 15
// R17 - every input, active reference included, is checked continuously
// R18 - any monitor failure raises an internal alarm for that input
// R19 - an alarmed input is excluded unless configured qualified anyway
// R20 - a disabled stage presents no edges on its internal clocks
module ref_input_stage
  import ref_input_pkg::*;
#(
  parameter int STAGES = NUM_STAGES
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic [STAGES-1:0]        posPin,
  input  wire logic [STAGES-1:0]        negPin,
  input  wire logic [NUM_GPIO-1:0]      gpioPin,
  input  wire stage_cfg_t [STAGES-1:0]  stageCfg,
  input  wire mon_fail_t [NUM_CLKS-1:0] monFail,
  input  wire logic [NUM_CLKS-1:0]      allowAlarm,
  output logic [NUM_CLKS-1:0]           intClk,
  output logic [NUM_CLKS-1:0]           syncPulse,
  output logic [NUM_CLKS-1:0][3:0]      syncAssocOut,
  output logic [NUM_CLKS-1:0]           refAlarm,
  output logic [NUM_CLKS-1:0]           refUsable,
  output logic [STAGES-1:0]             cfgError
);
  initial begin
    if (STAGES < 1 || STAGES > NUM_CLKS - NEG_IDX_OFS)
      $error("ref_input_stage: STAGES out of range"); // [R9]
  end

  // pin mode is legal only on the low stages; returns 1 if a stage may pair with a pin
  function automatic logic gpioCapable(input int s);
    return (s >= GPIO_STAGE_LO) && (s <= GPIO_STAGE_HI); // [R10] [R11]
  endfunction

  // gpio number feeding the upper index of a stage, or -1 when none is wired
  function automatic int gpioForStage(input int s);
    if (s == GPIO_STAGE_LO) return 0;
    return -1;
  endfunction

  logic [NUM_CLKS-1:0]      divOut;
  logic [NUM_CLKS-1:0]      present;
  logic [NUM_CLKS-1:0]      syncNext;
  logic [NUM_CLKS-1:0]      syncReg;
  logic [NUM_CLKS-1:0][3:0] assocNext;
  logic [NUM_CLKS-1:0][3:0] assocReg;
  logic [NUM_CLKS-1:0]      intNext;
  logic [NUM_CLKS-1:0]      intReg;
  logic                     gpio3Reg, gpio3Next;

  genvar g;
  generate
    for (g = 0; g < STAGES; g++) begin : gStage
      stage_mode_t effMode;
      logic        lowEn, highEn, highIn;
      path_cfg_t   highCfg;

      // an illegal pin mode request on an incapable stage falls back to differential
      assign effMode = (stageCfg[g].mode == MODE_DIFF_GPIO && !gpioCapable(g)) ? MODE_DIFF
                     : stageCfg[g].mode; // [R11]
      assign cfgError[g] = (stageCfg[g].mode == MODE_DIFF_GPIO && !gpioCapable(g))
                         || (stageCfg[g].mode == 2'h3);
      assign lowEn  = stageCfg[g].enable; // [R13]
      assign highEn = stageCfg[g].enable && (effMode == MODE_DUAL_SE
                    || (effMode == MODE_DIFF_GPIO && gpioForStage(g) >= 0)); // [R1]
      // dual single-ended takes the negative pin alone; pin mode on stage 0 takes pin 0
      assign highIn = (effMode == MODE_DUAL_SE) ? negPin[g]
                    : (gpioForStage(g) >= 0) ? gpioPin[0] : 1'b0; // [R6] [R10]
      always_comb begin
        highCfg = stageCfg[g].negPath; // [R7] [R8]
        if (effMode == MODE_DIFF_GPIO) highCfg.bypass = 1'b1; // [R12]
      end

      ref_pre_divider #(.W(DIV_W)) uLow (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .enable   (lowEn),
        .refIn    ((effMode == MODE_DUAL_SE) ? posPin[g] : (posPin[g] & ~negPin[g])),
        .bypass   (stageCfg[g].posPath.bypass),
        .invert   (stageCfg[g].posPath.invert),
        .divM1    (stageCfg[g].posPath.divM1),
        .clkOut   (divOut[g])
      ); // [R2] [R3]
      ref_pre_divider #(.W(DIV_W)) uHigh (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .enable   (highEn),
        .refIn    (highIn),
        .bypass   (highCfg.bypass),
        .invert   (highCfg.invert),
        .divM1    (highCfg.divM1),
        .clkOut   (divOut[g+NEG_IDX_OFS])
      ); // [R6] [R7]
      assign present[g]             = lowEn;
      assign present[g+NEG_IDX_OFS] = highEn && (g != GPIO_STAGE_HI || effMode != MODE_DIFF_GPIO);
    end
    for (g = STAGES; g < NEG_IDX_OFS; g++) begin : gReserved
      assign divOut[g]              = 1'b0; // [R9]
      assign divOut[g+NEG_IDX_OFS]  = 1'b0;
      assign present[g]             = 1'b0;
      assign present[g+NEG_IDX_OFS] = 1'b0;
    end
  endgenerate

  // pin 3 has no stage path of its own; it reaches index 15 bypassed when stage 3 pairs
  logic gpio3Active;
  assign gpio3Active = (STAGES > GPIO_STAGE_HI) && stageCfg[GPIO_STAGE_HI].enable
                     && stageCfg[GPIO_STAGE_HI].mode == MODE_DIFF_GPIO; // [R10]

  always_comb begin
    gpio3Next = gpio3Active ? (gpioPin[GPIO_STAGE_HI]
              ^ stageCfg[GPIO_STAGE_HI].negPath.invert) : 1'b0; // [R12] [R20]
    intNext   = divOut;
    if (gpio3Active) begin
      intNext[GPIO3_CLK_IDX] = gpio3Reg;
      intNext[GPIO_STAGE_HI + NEG_IDX_OFS] = 1'b0;
    end
    syncNext  = '0;
    assocNext = '0;
    for (int i = 0; i < STAGES; i++) begin
      if (stageCfg[i].syncUse) begin
        syncNext[i]  = intNext[i]; // [R14]
        assocNext[i] = stageCfg[i].syncAssoc;
        intNext[i]   = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gpio3Reg <= 1'b0;
      intReg   <= '0;
      syncReg  <= '0;
      assocReg <= '0;
    end else begin
      gpio3Reg <= gpio3Next;
      intReg   <= intNext;
      syncReg  <= syncNext;
      assocReg <= assocNext;
    end
  end

  assign intClk       = intReg;
  assign syncPulse    = syncReg;
  assign syncAssocOut = assocReg;

  logic [NUM_CLKS-1:0] monPresent;
  always_comb begin
    monPresent = present;
    if (gpio3Active) begin
      monPresent[GPIO3_CLK_IDX] = 1'b1;
    end
  end

  // monitors run regardless of which input is currently the active reference
  generate
    for (g = 0; g < NUM_CLKS; g++) begin : reference_monitor_instance
      ref_qualifier uQual (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .fail       (monFail[g]),
        .allowAlarm (allowAlarm[g]),
        .present    (monPresent[g]),
        .alarm      (refAlarm[g]),
        .usable     (refUsable[g])
      ); // [R16] [R17]
    end
  endgenerate

  reserved_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (STAGES < NEG_IDX_OFS) |-> !intClk[NEG_IDX_OFS-1]) else $error("reserved index toggled"); // [R9]
  stage_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!stageCfg[0].enable)[*3] |-> !intClk[0] && !intClk[NEG_IDX_OFS]) else $error("off stage"); // [R13]
  sync_steer_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    stageCfg[0].syncUse |=> !intClk[0]) else $error("sync input used as clock"); // [R14]
  // pairing must hold for two samples so the pin level reaches index 15 unmixed
  gpio3_map_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    gpio3Active [*2] |=> intClk[GPIO3_CLK_IDX] == $past(gpioPin[GPIO_STAGE_HI]
      ^ stageCfg[GPIO_STAGE_HI].negPath.invert, 2)) else $error("pin 3 not mapped"); // [R10]
endmodule : ref_input_stage
`default_nettype wire

// [ref_pre_divider.sv]
// one reference path: edge select, bypass or integer pre-divide
`default_nettype none
module ref_pre_divider
  import ref_input_pkg::*;
#(
  parameter int W = DIV_W
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic         enable,
  input  wire logic         refIn,
  input  wire logic         bypass,
  input  wire logic         invert,
  input  wire logic [W-1:0] divM1,
  output logic              clkOut
);
  initial begin
    if (W < 1 || W > DIV_W) $error("ref_pre_divider: W out of range");
  end

  logic         edgeIn;
  logic         prevReg, prevNext;
  logic [W-1:0] cntReg, cntNext;
  logic         outReg, outNext;
  logic [W-1:0] ratioM1;

  assign edgeIn  = refIn ^ invert; // [R5] [R8]
  // a ratio below the minimum is forced up so the counter always toggles sanely
  assign ratioM1 = (divM1 == '0) ? W'(DIV_MIN - 1) : divM1; // [R3]

  always_comb begin
    prevNext = edgeIn;
    cntNext  = cntReg;
    outNext  = outReg;
    if (!enable) begin
      cntNext = '0;
      outNext = 1'b0; // [R13] [R20]
    end else if (bypass) begin
      outNext = edgeIn; // [R4]
    end else if (edgeIn && !prevReg) begin
      if (cntReg >= ratioM1) begin
        cntNext = '0;
        outNext = 1'b1; // [R3]
      end else begin
        cntNext = cntReg + W'(1);
        if (cntReg == (ratioM1 >> 1)) outNext = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prevReg <= 1'b0;
      cntReg  <= '0;
      outReg  <= 1'b0;
    end else begin
      prevReg <= prevNext;
      cntReg  <= cntNext;
      outReg  <= outNext;
    end
  end

  assign clkOut = outReg;

  no_edge_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !enable |=> !clkOut) else $error("disabled path produced a high level"); // [R20]
  bypass_copy_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (enable && bypass) |=> clkOut == $past(edgeIn)) else $error("bypass not direct"); // [R4]
endmodule : ref_pre_divider
`default_nettype wire

// [ref_qualifier.sv]
// per-input alarm aggregation and qualification gate
`default_nettype none
module ref_qualifier
  import ref_input_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      rst_b,
  input  wire mon_fail_t fail,
  input  wire logic      allowAlarm,
  input  wire logic      present,
  output logic           alarm,
  output logic           usable
);
  logic alarmReg, alarmNext;
  logic useReg, useNext;

  always_comb begin
    alarmNext = |fail; // [R17] [R18]
    useNext   = present && (!alarmNext || allowAlarm); // [R19]
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarmReg <= 1'b0;
      useReg   <= 1'b0;
    end else begin
      alarmReg <= alarmNext;
      useReg   <= useNext;
    end
  end

  assign alarm  = alarmReg;
  assign usable = useReg;

  alarm_blocks_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (|fail && !allowAlarm) |=> !usable) else $error("alarmed input usable"); // [R19]
  alarm_raise_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (|fail) |=> alarm) else $error("failure without alarm"); // [R18]
endmodule : ref_qualifier
`default_nettype wire

// [reference_input_stage_test.sv]
// self-checking bench for the reference input stages
`default_nettype none
module reference_input_stage_test import ref_input_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        en;
    logic [1:0]  md;
    logic        iP;
    logic        iN;
    logic [15:0] clk;
    logic [7:0]  err;
  } row_t;

  logic             core_clk, rst_b, srcRun, useSrc, srcOut;
  logic [7:0]       posDrv, negDrv, cfgError;
  logic [3:0]       gpioPin, halfPer;
  stage_cfg_t [7:0] cfg;
  mon_fail_t [15:0] monFail;
  logic [15:0]      allowAlarm, intClk, syncPulse, refAlarm, refUsable;
  logic [15:0][3:0] syncAssocOut;
  wire logic [7:0]  posPin = {posDrv[7:1], useSrc ? srcOut : posDrv[0]};
  wire logic [7:0]  negPin = {negDrv[7:1], useSrc ? srcOut : negDrv[0]};
  int               error_cnt = 0;
  int               tests_run = 0;
  int               cPos, cNeg;
  int               ratio [3] = '{2, 3, 5};
  // pins: pos 5A, neg 3C, gpio 9; every stage gets the same setting
  row_t rows [9] = '{
    '{1'b1, 2'h0, 1'b0, 1'b0, 16'h0042, 8'h00},
    '{1'b1, 2'h0, 1'b1, 1'b0, 16'h00BD, 8'h00},
    '{1'b1, 2'h1, 1'b0, 1'b0, 16'h3C5A, 8'h00},
    '{1'b1, 2'h1, 1'b1, 1'b0, 16'h3CA5, 8'h00},
    '{1'b1, 2'h1, 1'b0, 1'b1, 16'hC35A, 8'h00},
    '{1'b1, 2'h2, 1'b0, 1'b0, 16'h8142, 8'hF0},
    '{1'b1, 2'h2, 1'b0, 1'b1, 16'h0042, 8'hF0},
    '{1'b1, 2'h3, 1'b0, 1'b0, 16'h0042, 8'hFF},
    '{1'b0, 2'h1, 1'b1, 1'b1, 16'h0000, 8'h00}
  };

  ref_input_stage #(.STAGES(8)) dut (.core_clk(core_clk), .rst_b(rst_b), .posPin(posPin),
    .negPin(negPin), .gpioPin(gpioPin), .stageCfg(cfg), .monFail(monFail),
    .allowAlarm(allowAlarm), .intClk(intClk), .syncPulse(syncPulse),
    .syncAssocOut(syncAssocOut), .refAlarm(refAlarm), .refUsable(refUsable),
    .cfgError(cfgError));
  ref_clock_source src (.core_clk(core_clk), .run(srcRun), .halfPer(halfPer), .pinOut(srcOut));

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic check_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // divided clocks may straddle the window edge, so one edge of slack
  task automatic check_cnt(input string what, input int exp, input int got);
    tests_run++;
    if (got < exp - 1 || got > exp + 1) begin
      error_cnt++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic set_all(input logic en, input logic [1:0] md, input logic iP, input logic iN,
                         input logic byp, input int dP, input int dN);
    for (int i = 0; i < 8; i++) begin
      cfg[i].enable = en;
      cfg[i].mode = stage_mode_t'(md);
      cfg[i].posPath = '{byp, iP, 16'(dP - 1)};
      cfg[i].negPath = '{byp, iN, 16'(dN - 1)};
      cfg[i].syncUse = 1'b0;
      cfg[i].syncAssoc = 4'h0;
      cfg[i].input_nominal_frequency_field = 32'h0000_0064;
    end
  endtask

  task automatic count_edges(input int n, output int cP, output int cN);
    logic pP, pN;
    cP = 0;
    cN = 0;
    repeat (n) begin
      pP = intClk[0];
      pN = intClk[8];
      step(1);
      if (intClk[0] === 1'b1 && pP === 1'b0) cP++;
      if (intClk[8] === 1'b1 && pN === 1'b0) cN++;
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    #40000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    rst_b = 1'b0;
    srcRun = 1'b0;
    useSrc = 1'b0;
    halfPer = 4'h2;
    posDrv = 8'h5A;
    negDrv = 8'h3C;
    gpioPin = 4'h9;
    monFail = '0;
    allowAlarm = '0;
    set_all(1'b1, 2'h1, 1'b0, 1'b0, 1'b1, 2, 2);
    step(2);
    rst_b = 1'b1;
    foreach (rows[r]) begin
      set_all(rows[r].en, rows[r].md, rows[r].iP, rows[r].iN, 1'b1, 2, 2);
      step(3);
      check_vec("intClk", rows[r].clk, intClk);
      check_vec("cfgError", {8'h00, rows[r].err}, {8'h00, cfgError});
    end
    set_all(1'b1, 2'h1, 1'b0, 1'b0, 1'b1, 2, 2);
    cfg[1].syncUse = 1'b1;
    cfg[1].syncAssoc = 4'h5;
    step(3);
    check_vec("syncPulse", 16'h0002, syncPulse);
    check_vec("syncAssoc", 16'h0005, {12'h000, syncAssocOut[1]});
    check_vec("intClk with sync", 16'h3C58, intClk);
    for (int k = 0; k < 4; k++) begin
      monFail[3] = (k == 3) ? 3'b000 : 3'b001 << k;
      for (int a = 0; a < 2; a++) begin
        allowAlarm[3] = a[0];
        step(3);
        check_vec("refAlarm", {15'h0, k != 3}, {15'h0, refAlarm[3]});
        check_vec("refUsable", {15'h0, k == 3 || a == 1}, {15'h0, refUsable[3]});
      end
    end
    monFail = {16{3'b100}};
    allowAlarm = '0;
    step(3);
    check_vec("refAlarm all", 16'hFFFF, refAlarm);
    monFail = '0;
    set_all(1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 2, 2);
    cfg[2].enable = 1'b0;
    step(3);
    check_vec("refUsable present", 16'h00FB, refUsable);
    // stage 0 in dual single-ended mode, both pins fed by the source
    set_all(1'b1, 2'h1, 1'b0, 1'b0, 1'b0, 2, 4);
    useSrc = 1'b1;
    srcRun = 1'b1;
    foreach (ratio[j]) begin
      cfg[0].posPath.divM1 = 16'(ratio[j] - 1);
      cfg[0].negPath.invert = j[0];
      step(8);
      count_edges(240, cPos, cNeg);
      check_cnt("pos divided edges", 60 / ratio[j], cPos);
      check_cnt("neg divided edges", 15, cNeg);
    end
    rst_b = 1'b0;
    step(1);
    check_vec("intClk in reset", 16'h0000, intClk);
    check_vec("refUsable in reset", 16'h0000, refUsable);
    rst_b = 1'b1;
    step(2);
    report_and_stop();
  end
endmodule // reference_input_stage_test
`default_nettype wire
